// ===== hw/rfg_cfg.svh
`ifndef RFG_CFG_SVH
`define RFG_CFG_SVH
// Behaviour
// - Executing from unused ROM raises chip reset
// - Guard enabled only by startup code option
// - Guard reset sets cause flag for software
// - Region: parameter lower bound to 7:0FFFF
// - Segment bit 3 ignored in comparison
// - Loopback routes unit transmit into receive
// - Pin output follows alternate-function select only
// - Loopback receive needs no pin selection
// - Six loopback enable bits, reset zero

`define RFG_ADDR_COMM_TEST 12'h000
`define RFG_ADDR_SAFETY_STAT 12'h004
`define RFG_ADDR_IRQ_STAT 12'h008
`define RFG_ADDR_IRQ_MASK 12'h00c
`define RFG_ADDR_OPTION 12'h010

`define RFG_COMM_TEST_RST 16'h0000
`define RFG_COMM_TEST_WMASK 16'h113f
`define RFG_SAFETY_STAT_RST 8'h00
`define RFG_SAFETY_ROM_BIT 0
`define RFG_IRQ_RST 2'h0
`define RFG_IRQ_HIT_BIT 0
`define RFG_IRQ_IGNORED_BIT 1

`define RFG_GUARD_TOP 20'h7ffff
`define RFG_GUARD_LOW_DEF 20'h3ffc0
`define RFG_SEG_KEEP 4'h7

`define RFG_CLK_PERIOD_NS 4
`define RFG_RST_HOLD_NS 16
`define RFG_RST_HOLD_CYC ((`RFG_RST_HOLD_NS + `RFG_CLK_PERIOD_NS - 1) / `RFG_CLK_PERIOD_NS)
`define RFG_NUM_UNITS 6
`endif

// ===== hw/rfg_pkg.sv
`include "rfg_cfg.svh"
package rfg_pkg;
	typedef struct packed {
		logic valid;
		logic [3:0] seg;
		logic [15:0] pc;
	} rfg_fetch_s;

	typedef enum logic {
		RFG_IDLE = 1'b0,
		RFG_HOLD = 1'b1
	} rfg_guard_e;

	typedef logic [`RFG_NUM_UNITS-1:0] rfg_unit_t;

	// Segment bit 3 does not exist in the fetch path
	function automatic logic [19:0] rfg_fetch_addr(input rfg_fetch_s f);
		logic [3:0] seg;
		seg = f.seg & `RFG_SEG_KEEP;
		rfg_fetch_addr = {1'b0, seg[2:0], f.pc};
	endfunction : rfg_fetch_addr
endpackage : rfg_pkg

// ===== hw/rfg_fetch_cmp.sv
`include "rfg_cfg.svh"
module rfg_fetch_cmp import rfg_pkg::*; #(
	parameter logic [19:0] GUARD_LOW = `RFG_GUARD_LOW_DEF
) (
	// Fetch in
	input wire rfg_fetch_s fetch,
	// Result
	output logic hit
);
	logic [19:0] addr;

	always_comb begin
		addr = rfg_fetch_addr(fetch);
		hit = fetch.valid && (addr >= GUARD_LOW) && (addr <= `RFG_GUARD_TOP);
	end
endmodule : rfg_fetch_cmp

// ===== hw/rfg_loopback.sv
module rfg_loopback import rfg_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Control
	input wire rfg_unit_t loop_en,
	input wire rfg_unit_t port_alt_sel,
	// Serial units
	input wire rfg_unit_t unit_txd,
	output rfg_unit_t unit_rxd_q,
	// Pins
	input wire rfg_unit_t pin_rxd,
	output rfg_unit_t pin_txd_q,
	output rfg_unit_t pin_txd_oe_q
);
	rfg_unit_t rx_s1_q, rx_s2_q;
	rfg_unit_t rx_s1_d, rx_s2_d, unit_rxd_d, pin_txd_d, pin_txd_oe_d;

	always_comb begin
		rx_s1_d = pin_rxd;
		rx_s2_d = rx_s1_q;
		unit_rxd_d = (loop_en & unit_txd) | (~loop_en & rx_s2_q);
		// Idle high on an undriven line keeps a UART receiver quiet
		pin_txd_d = unit_txd | ~port_alt_sel;
		pin_txd_oe_d = port_alt_sel;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			rx_s1_q <= '1;
			rx_s2_q <= '1;
			unit_rxd_q <= '1;
			pin_txd_q <= '1;
			pin_txd_oe_q <= '0;
		end else begin
			rx_s1_q <= rx_s1_d;
			rx_s2_q <= rx_s2_d;
			unit_rxd_q <= unit_rxd_d;
			pin_txd_q <= pin_txd_d;
			pin_txd_oe_q <= pin_txd_oe_d;
		end
	end

	loop_route_a: assert property (@(posedge clock) disable iff (srst)
		!srst |=> ((unit_rxd_q ^ $past(unit_txd)) & $past(loop_en)) == '0)
		else $error("loopback receive differs from transmit");
	pin_select_a: assert property (@(posedge clock) disable iff (srst)
		!srst |=> (pin_txd_oe_q == $past(port_alt_sel)) &&
		((pin_txd_q ^ $past(unit_txd)) & $past(port_alt_sel)) == '0)
		else $error("pin output not following alternate select");
endmodule : rfg_loopback

// ===== hw/rfg_top.sv
// Chosen here: the placing of the registers and the APB slave port.
`include "rfg_cfg.svh"
module rfg_top import rfg_pkg::*; #(
	parameter logic [19:0] GUARD_LOW = `RFG_GUARD_LOW_DEF
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Code option strap
	input wire logic option_guard_pin,
	// CPU fetch
	input wire rfg_fetch_s fetch,
	// Serial units
	input wire rfg_unit_t unit_txd,
	output rfg_unit_t unit_rxd,
	input wire rfg_unit_t port_alt_sel,
	// Port pins
	input wire rfg_unit_t pin_rxd,
	output rfg_unit_t pin_txd,
	output rfg_unit_t pin_txd_oe,
	// System
	output logic chip_wide_reset,
	output logic irq
);
	localparam logic [2:0] HOLD_LAST = 3'(`RFG_RST_HOLD_CYC - 1);

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] t);
		addr_is = (a[11:2] == t[11:2]);
	endfunction : addr_is

	// Code option capture
	logic opt_s1_q, opt_s2_q, opt_loaded_q, opt_en_q;
	logic opt_s1_d, opt_s2_d, opt_loaded_d, opt_en_d;
	logic guard_en;

	always_comb begin
		opt_s1_d = option_guard_pin;
		opt_s2_d = opt_s1_q;
		opt_loaded_d = opt_loaded_q;
		opt_en_d = opt_en_q;
		// Latched once after release; software cannot change it later
		if (!opt_loaded_q) begin
			opt_loaded_d = 1'b1;
			opt_en_d = opt_s2_q;
		end
		guard_en = opt_loaded_q && opt_en_q;
	end

	always_ff @(posedge clock) begin
		// Strap chain runs through reset so the option is settled at release
		opt_s1_q <= opt_s1_d;
		opt_s2_q <= opt_s2_d;
		if (srst) begin
			opt_loaded_q <= 1'b0;
			opt_en_q <= 1'b0;
		end else begin
			opt_loaded_q <= opt_loaded_d;
			opt_en_q <= opt_en_d;
		end
	end

	// Fetch comparison
	logic fetch_hit;

	rfg_fetch_cmp #(
		.GUARD_LOW(GUARD_LOW)
	) u_cmp (
		.fetch(fetch),
		.hit(fetch_hit)
	);

	// Guard reset sequencer
	rfg_guard_e state_q, state_d;
	logic [2:0] hold_cnt_q, hold_cnt_d;
	logic chip_rst_q, chip_rst_d;
	logic viol_evt, ign_evt;

	always_comb begin
		state_d = state_q;
		hold_cnt_d = hold_cnt_q;
		chip_rst_d = chip_rst_q;
		viol_evt = fetch_hit && guard_en && (state_q == RFG_IDLE);
		ign_evt = fetch_hit && !guard_en;
		unique case (state_q)
			RFG_IDLE: begin
				if (viol_evt) begin
					state_d = RFG_HOLD;
					hold_cnt_d = HOLD_LAST;
					chip_rst_d = 1'b1;
				end
			end
			RFG_HOLD: begin
				// Further hits are moot while the chip is being reset
				if (hold_cnt_q == 3'h0) begin
					state_d = RFG_IDLE;
					chip_rst_d = 1'b0;
				end else begin
					hold_cnt_d = hold_cnt_q - 3'h1;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= RFG_IDLE;
			hold_cnt_q <= 3'h0;
			chip_rst_q <= 1'b0;
		end else begin
			state_q <= state_d;
			hold_cnt_q <= hold_cnt_d;
			chip_rst_q <= chip_rst_d;
		end
	end

	assign chip_wide_reset = chip_rst_q;

	// Register file and APB slave
	logic [15:0] comm_test_q, comm_test_d;
	logic [7:0] safety_stat_q, safety_stat_d;
	logic [1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
	logic access, wr_done;
	logic mapped;
	logic [31:0] rd_word;
	logic [1:0] irq_set;

	always_comb begin
		access = psel && penable;
		wr_done = access && pready_q && pwrite;
		mapped = addr_is(paddr, `RFG_ADDR_COMM_TEST) || addr_is(paddr, `RFG_ADDR_SAFETY_STAT) ||
			addr_is(paddr, `RFG_ADDR_IRQ_STAT) || addr_is(paddr, `RFG_ADDR_IRQ_MASK) ||
			addr_is(paddr, `RFG_ADDR_OPTION);
		rd_word = 32'h0000_0000;
		if (addr_is(paddr, `RFG_ADDR_COMM_TEST)) begin
			rd_word = {16'h0000, comm_test_q};
		end else if (addr_is(paddr, `RFG_ADDR_SAFETY_STAT)) begin
			rd_word = {24'h00_0000, safety_stat_q};
		end else if (addr_is(paddr, `RFG_ADDR_IRQ_STAT)) begin
			rd_word = {30'h0000_0000, irq_stat_q};
		end else if (addr_is(paddr, `RFG_ADDR_IRQ_MASK)) begin
			rd_word = {30'h0000_0000, irq_mask_q};
		end else if (addr_is(paddr, `RFG_ADDR_OPTION)) begin
			rd_word = {30'h0000_0000, opt_loaded_q, opt_en_q};
		end
		// One wait state: answer lands on the second access cycle
		pready_d = access && !pready_q;
		prdata_d = (pready_d && !pwrite) ? rd_word : 32'h0000_0000;
		pslverr_d = pready_d && !mapped;

		comm_test_d = comm_test_q;
		if (wr_done && addr_is(paddr, `RFG_ADDR_COMM_TEST)) begin
			comm_test_d = pwdata[15:0] & `RFG_COMM_TEST_WMASK;
		end
		safety_stat_d = safety_stat_q;
		if (wr_done && addr_is(paddr, `RFG_ADDR_SAFETY_STAT)) begin
			safety_stat_d = safety_stat_q & ~pwdata[7:0];
		end
		// Set after clear so a same-cycle event survives
		if (viol_evt) begin
			safety_stat_d[`RFG_SAFETY_ROM_BIT] = 1'b1;
		end
		irq_set = 2'h0;
		irq_set[`RFG_IRQ_HIT_BIT] = viol_evt;
		irq_set[`RFG_IRQ_IGNORED_BIT] = ign_evt;
		irq_stat_d = irq_stat_q;
		if (wr_done && addr_is(paddr, `RFG_ADDR_IRQ_STAT)) begin
			irq_stat_d = irq_stat_q & ~pwdata[1:0];
		end
		irq_stat_d = irq_stat_d | irq_set;
		irq_mask_d = irq_mask_q;
		if (wr_done && addr_is(paddr, `RFG_ADDR_IRQ_MASK)) begin
			irq_mask_d = pwdata[1:0];
		end
		irq_d = |(irq_stat_d & irq_mask_d);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			comm_test_q <= `RFG_COMM_TEST_RST;
			safety_stat_q <= `RFG_SAFETY_STAT_RST;
			irq_stat_q <= `RFG_IRQ_RST;
			irq_mask_q <= `RFG_IRQ_RST;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			comm_test_q <= comm_test_d;
			safety_stat_q <= safety_stat_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			irq_q <= irq_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;

	// Serial loopback
	rfg_loopback u_loop (
		.clock(clock),
		.srst(srst),
		.loop_en(comm_test_q[`RFG_NUM_UNITS-1:0]),
		.port_alt_sel(port_alt_sel),
		.unit_txd(unit_txd),
		.unit_rxd_q(unit_rxd),
		.pin_rxd(pin_rxd),
		.pin_txd_q(pin_txd),
		.pin_txd_oe_q(pin_txd_oe)
	);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	rom_reset_fire_a: assert property (
		(fetch_hit && guard_en && !chip_wide_reset) |=>
		chip_wide_reset [*4] ##1 !chip_wide_reset)
		else $error("guard reset not asserted for hold time");
	option_gate_a: assert property (
		(opt_loaded_q && !opt_en_q) |-> !chip_wide_reset)
		else $error("guard reset while code option disabled");
	option_frozen_a: assert property (
		opt_loaded_q |=> $stable(opt_en_q) && opt_loaded_q)
		else $error("code option changed after load");
	cause_flag_a: assert property (
		$rose(chip_wide_reset) |-> safety_stat_q[`RFG_SAFETY_ROM_BIT] && irq_stat_q[0])
		else $error("cause flag missing at guard reset");
	region_top_a: assert property (
		(fetch.valid && fetch.seg[2:0] == 3'h7 && fetch.pc == 16'hffff) |-> fetch_hit)
		else $error("top of region not detected");
	region_low_a: assert property (
		(fetch.valid && rfg_fetch_addr(fetch) < GUARD_LOW) |-> !fetch_hit)
		else $error("hit below lower boundary");
	seg_alias_a: assert property (
		(fetch.valid && fetch.seg == 4'hf && fetch.pc == 16'hffff) |-> fetch_hit)
		else $error("segment bit 3 not ignored");
	fetch_only_a: assert property (
		!fetch.valid |-> !fetch_hit)
		else $error("hit without an executed fetch");
	comm_bits_a: assert property (
		(comm_test_q & ~`RFG_COMM_TEST_WMASK) == 16'h0000)
		else $error("reserved loopback bits set");
	apb_answer_a: assert property (
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("APB answer not one wait state");
	irq_level_a: assert property (
		(|(irq_stat_q & irq_mask_q)) == irq)
		else $error("interrupt output not matching status and mask");
	no_spurious_a: assert property (
		$rose(chip_wide_reset) |-> $past(viol_evt))
		else $error("guard reset without a guarded fetch");
	ignore_flag_a: assert property (
		(!srst && fetch_hit && !guard_en) |=> irq_stat_q[`RFG_IRQ_IGNORED_BIT] && !chip_wide_reset)
		else $error("ignored hit not flagged");
	cause_sticky_a: assert property (
		(safety_stat_q[`RFG_SAFETY_ROM_BIT] && !(psel && pwrite)) |=>
		safety_stat_q[`RFG_SAFETY_ROM_BIT])
		else $error("cause flag lost without a clear");
endmodule : rfg_top

// ===== tb/rfg_far_side.sv
module rfg_far_side import rfg_pkg::*; (
	// Clock
	input wire logic clock,
	// Toward the block
	output rfg_fetch_s fetch,
	output rfg_unit_t unit_txd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fetch = '0;
		unit_txd = '1;
	end
	// Strobe lasts one cycle; address scrambled after so nothing stale matches
	task automatic fetch_one(input logic [3:0] seg, input logic [15:0] pc);
		@(posedge clock);
		fetch <= '{valid: 1'b1, seg: seg, pc: pc};
		@(posedge clock);
		fetch <= '{valid: 1'b0, seg: ~seg, pc: ~pc};
	endtask : fetch_one
	task automatic send(input rfg_unit_t v);
		@(posedge clock);
		unit_txd <= v;
	endtask : send
endmodule : rfg_far_side

// ===== tb/tb_rom_fetch_guard_serial_loopback.sv
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_rom_fetch_guard_serial_loopback import rfg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [19:0] LOW = 20'h3ffc0;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} rfg_row_s;
	rfg_row_s rows [8] = '{
		'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h010, 32'h0, 32'h3, 1'b0}, '{1'b1, 12'h000, 32'hffffffff, 32'h0, 1'b0},
		'{1'b0, 12'h000, 32'h0, 32'h113f, 1'b0}, '{1'b1, 12'h010, 32'h0, 32'h0, 1'b0},
		'{1'b0, 12'h010, 32'h0, 32'h3, 1'b0}, '{1'b0, 12'h020, 32'h0, 32'h0, 1'b1}};
	logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, option_guard_pin = 1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, chip_wide_reset, irq, er;
	rfg_fetch_s fetch;
	rfg_unit_t unit_txd, unit_rxd, pin_txd, pin_txd_oe, port_alt_sel = '0, pin_rxd = '1;
	int miscompares = 0, tests_run = 0, cyc = 0;
	always #2 clock = ~clock;
	rfg_far_side far (.clock(clock), .fetch(fetch), .unit_txd(unit_txd));
	rfg_top #(.GUARD_LOW(LOW)) dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .option_guard_pin(option_guard_pin), .fetch(fetch),
		.unit_txd(unit_txd), .unit_rxd(unit_rxd), .port_alt_sel(port_alt_sel),
		.pin_rxd(pin_rxd), .pin_txd(pin_txd), .pin_txd_oe(pin_txd_oe),
		.chip_wide_reset(chip_wide_reset), .irq(irq));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		forever begin
			@(posedge clock);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rdchk(input logic [11:0] a, input logic [31:0] q);
		apb(0, a, 32'h0);
		`CHK(rd, q)
	endtask : rdchk
	task automatic fetch_chk(input logic [3:0] s, input logic [15:0] p, input logic h);
		far.fetch_one(s, p);
		for (int k = 0; k < 5; k++) begin
			@(posedge clock);
			`CHK(chip_wide_reset, h && k < 4)
		end
	endtask : fetch_chk
	initial begin
		repeat (6) @(posedge clock);
		srst <= 0;
		@(posedge clock);
		`CHK({unit_rxd, pin_txd, pin_txd_oe}, 18'h3ffc0)
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			`CHK(er, rows[i].e)
			if (!rows[i].w)
				`CHK(rd, rows[i].q)
		end
		$display("register rows done");
		apb(1, 12'h000, 32'h5);
		port_alt_sel <= 6'h03;
		pin_rxd <= 6'h30;
		far.send(6'h0f);
		repeat (4) @(posedge clock);
		`CHK(unit_rxd, 6'h35)
		`CHK({pin_txd, pin_txd_oe}, 12'hfc3)
		far.send(6'h30);
		repeat (2) @(posedge clock);
		`CHK(unit_rxd, 6'h30)
		`CHK(pin_txd, 6'h3c)
		$display("loopback done");
		fetch_chk(4'h3, 16'hffbf, 1'b0);
		fetch_chk(4'h3, 16'hffc0, 1'b1);
		fetch_chk(4'hb, 16'hffc0, 1'b1);
		fetch_chk(4'h8, 16'hffff, 1'b0);
		fetch_chk(4'hf, 16'hffff, 1'b1);
		fetch_chk(4'h7, 16'hffff, 1'b1);
		rdchk(12'h004, 32'h1);
		rdchk(12'h008, 32'h1);
		`CHK(irq, 1'b0)
		apb(1, 12'h00c, 32'h1);
		repeat (2) @(posedge clock);
		`CHK(irq, 1'b1)
		apb(1, 12'h008, 32'h1);
		apb(1, 12'h004, 32'h1);
		repeat (2) @(posedge clock);
		`CHK(irq, 1'b0)
		rdchk(12'h004, 32'h0);
		$display("guard done");
		option_guard_pin <= 0;
		srst <= 1;
		repeat (6) @(posedge clock);
		srst <= 0;
		repeat (2) @(posedge clock);
		rdchk(12'h010, 32'h2);
		fetch_chk(4'h3, 16'hffc0, 1'b0);
		rdchk(12'h008, 32'h2);
		rdchk(12'h004, 32'h0);
		$display("option off done");
		wrap_up();
	end
endmodule : tb_rom_fetch_guard_serial_loopback
